//--- logic/amh_pkg.sv
// constants, field layouts and carrier types of the error mask, control and header log bank
`default_nettype none

package amh_pkg;

    localparam int unsigned AMH_ADDR_W = 12;

    // register byte addresses
    localparam logic [11:0] AMH_CORR_STATUS_OFF = 12'h110;
    localparam logic [11:0] AMH_CORR_MASK_OFF   = 12'h114;
    localparam logic [11:0] AMH_ERR_CTL_OFF     = 12'h118;
    localparam logic [11:0] AMH_HDR_LOG0_OFF    = 12'h11c;
    localparam logic [11:0] AMH_HDR_LOG1_OFF    = 12'h120;
    localparam logic [11:0] AMH_HDR_LOG2_OFF    = 12'h124;
    localparam logic [11:0] AMH_HDR_LOG3_OFF    = 12'h128;

    // correctable event bit positions, shared by status and mask
    localparam int unsigned AMH_RECEIVER_ERROR_BIT  = 0;
    localparam int unsigned AMH_BAD_TLP_BIT         = 6;
    localparam int unsigned AMH_BAD_LINK_BIT        = 7;
    localparam int unsigned AMH_REPLAY_ROLLOVER_BIT = 8;
    localparam int unsigned AMH_REPLAY_TIMEOUT_BIT  = 12;
    localparam int unsigned AMH_ADVISORY_BIT        = 13;
    localparam logic [31:0] AMH_CORR_DEFINED = 32'h0000_31c1;
    localparam logic [31:0] AMH_MASK_RESET   = 32'h0000_2000;
    localparam logic [31:0] AMH_STATUS_RESET = 32'h0000_0000;

    // error control layout
    localparam int unsigned AMH_FEP_LSB      = 0;
    localparam int unsigned AMH_FEP_W        = 5;
    localparam int unsigned AMH_GEN_CAP_BIT  = 5;
    localparam int unsigned AMH_GEN_EN_BIT   = 6;
    localparam int unsigned AMH_CHK_CAP_BIT  = 7;
    localparam int unsigned AMH_CHK_EN_BIT   = 8;
    localparam logic        AMH_CAP_RESET    = 1'b1;
    localparam logic        AMH_EN_RESET     = 1'b0;
    localparam logic [4:0]  AMH_FEP_RESET    = 5'h00;
    localparam logic [31:0] AMH_HDR_RESET    = 32'h0000_0000;

    // axi response codes
    localparam logic [1:0] AMH_RESP_OKAY   = 2'h0;
    localparam logic [1:0] AMH_RESP_DECERR = 2'h3;

    // one uncorrectable error report with the offending header, dw0 lowest
    typedef struct packed {
        logic             valid;
        logic [4:0]       bit_pos;
        logic [3:0][31:0] hdr;
    } amh_unc_t;

    // byte-enable merge of write data into an old register value
    function automatic logic [31:0] amh_merge(input logic [31:0] old_val,
                                              input logic [31:0] wdata,
                                              input logic [3:0]  strb);
        logic [31:0] be;
        be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_val & ~be) | (wdata & be);
    endfunction

endpackage

`default_nettype wire

//--- logic/amh_aer_regs.sv
// error mask, error control and header log registers of one port, axi4-lite slave
`default_nettype none

module amh_aer_regs (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              hot_reset,
    input  wire logic              cfg_unlock,
    input  wire logic [31:0]       corr_event,
    input  wire amh_pkg::amh_unc_t unc_err,
    input  wire logic              unc_ack,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [11:0]       s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   irq,
    output logic                   corr_report,
    output logic                   crc_gen_en,
    output logic                   crc_chk_en,
    output logic [4:0]             first_error_pointer
);

    logic [11:0]      waddr_reg;
    logic [31:0]      wdata_reg;
    logic [3:0]       wstrb_reg;
    logic             do_write;
    logic [31:0]      correctable_status_reg;
    logic [31:0]      correctable_mask_reg;
    logic             crc_gen_capable_reg;
    logic             crc_check_capable_reg;
    logic             pending_reg;
    logic [3:0][31:0] header_log_word_reg;
    logic [31:0]      ctl_view;
    logic [31:0]      events;
    logic             capture;
    logic             wr_status;
    logic             wr_mask;
    logic             wr_ctl;
    logic [32:0]      wr_lookup;
    logic [32:0]      rd_lookup;

    // decode helper used by both the write and the read path
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction

    // reads have no side effects, so one mux serves every read
    function automatic logic [32:0] read_word(input logic [11:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        if (addr_hit(a, amh_pkg::AMH_CORR_STATUS_OFF)) begin
            r = {1'b0, correctable_status_reg};
        end else if (addr_hit(a, amh_pkg::AMH_CORR_MASK_OFF)) begin
            r = {1'b0, correctable_mask_reg};
        end else if (addr_hit(a, amh_pkg::AMH_ERR_CTL_OFF)) begin
            r = {1'b0, ctl_view};
        end else if (addr_hit(a, amh_pkg::AMH_HDR_LOG0_OFF)) begin
            r = {1'b0, header_log_word_reg[0]};
        end else if (addr_hit(a, amh_pkg::AMH_HDR_LOG1_OFF)) begin
            r = {1'b0, header_log_word_reg[1]};
        end else if (addr_hit(a, amh_pkg::AMH_HDR_LOG2_OFF)) begin
            r = {1'b0, header_log_word_reg[2]};
        end else if (addr_hit(a, amh_pkg::AMH_HDR_LOG3_OFF)) begin
            r = {1'b0, header_log_word_reg[3]};
        end
        return r;
    endfunction

    // control register as software sees it; bits 31:9 stay zero
    always_comb begin
        ctl_view = 32'h0000_0000;
        ctl_view[amh_pkg::AMH_FEP_LSB +: amh_pkg::AMH_FEP_W] = first_error_pointer;
        ctl_view[amh_pkg::AMH_GEN_CAP_BIT] = crc_gen_capable_reg;
        ctl_view[amh_pkg::AMH_GEN_EN_BIT]  = crc_gen_en;
        ctl_view[amh_pkg::AMH_CHK_CAP_BIT] = crc_check_capable_reg;
        ctl_view[amh_pkg::AMH_CHK_EN_BIT]  = crc_chk_en;
    end

    // write strobes: address and data both held, response not yet pending
    assign do_write  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_status = do_write && addr_hit(waddr_reg, amh_pkg::AMH_CORR_STATUS_OFF);
    assign wr_mask   = do_write && addr_hit(waddr_reg, amh_pkg::AMH_CORR_MASK_OFF);
    assign wr_ctl    = do_write && addr_hit(waddr_reg, amh_pkg::AMH_ERR_CTL_OFF);
    assign events    = corr_event & amh_pkg::AMH_CORR_DEFINED;
    // lookups kept as nets: a bit-select straight off a call result is not portable
    assign wr_lookup = read_word(waddr_reg);
    assign rd_lookup = read_word(s_axi_araddr);
    // a new error may load the log once the old one is acknowledged, even in the same cycle
    assign capture   = unc_err.valid && (!pending_reg || unc_ack);

    // write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            waddr_reg     <= 12'h000;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                waddr_reg     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
            end
            // reopen both channels only once the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= amh_pkg::AMH_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_lookup[32] ? amh_pkg::AMH_RESP_DECERR
                                          : amh_pkg::AMH_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel, data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= amh_pkg::AMH_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_lookup[31:0];
            s_axi_rresp   <= rd_lookup[32] ? amh_pkg::AMH_RESP_DECERR
                                           : amh_pkg::AMH_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // correctable status: event set wins over a write-one clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            correctable_status_reg <= amh_pkg::AMH_STATUS_RESET;
        end else begin
            correctable_status_reg <=
                (correctable_status_reg
                 & ~(wr_status ? amh_pkg::amh_merge(32'h0000_0000, wdata_reg, wstrb_reg)
                               : 32'h0000_0000)
                 & amh_pkg::AMH_CORR_DEFINED)
                | events;
        end
    end

    // mask: sticky, so hot reset leaves it alone; undefined bits never store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            correctable_mask_reg <= amh_pkg::AMH_MASK_RESET;
        end else if (wr_mask) begin
            correctable_mask_reg <= amh_pkg::amh_merge(correctable_mask_reg, wdata_reg,
                                                       wstrb_reg)
                                    & amh_pkg::AMH_CORR_DEFINED;
        end
    end

    // crc enables are sticky and steer the packet path outside
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crc_gen_en <= amh_pkg::AMH_EN_RESET;
            crc_chk_en <= amh_pkg::AMH_EN_RESET;
        end else if (wr_ctl && wstrb_reg[0]) begin
            crc_gen_en <= wdata_reg[amh_pkg::AMH_GEN_EN_BIT];
        end
        if (aresetn && wr_ctl && wstrb_reg[1]) begin
            crc_chk_en <= wdata_reg[amh_pkg::AMH_CHK_EN_BIT];
        end
    end

    // capability bits are not sticky: any reset restores them, writes need the lock open
    always_ff @(posedge aclk) begin
        if (!aresetn || hot_reset) begin
            crc_gen_capable_reg   <= amh_pkg::AMH_CAP_RESET;
            crc_check_capable_reg <= amh_pkg::AMH_CAP_RESET;
        end else if (wr_ctl && cfg_unlock) begin
            if (wstrb_reg[0]) begin
                crc_gen_capable_reg <= wdata_reg[amh_pkg::AMH_GEN_CAP_BIT];
            end
            if (wstrb_reg[0]) begin
                crc_check_capable_reg <= wdata_reg[amh_pkg::AMH_CHK_CAP_BIT];
            end
        end
    end

    // first error pointer and header log, frozen until the error is acknowledged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_reg         <= 1'b0;
            first_error_pointer <= amh_pkg::AMH_FEP_RESET;
            header_log_word_reg <= {4{amh_pkg::AMH_HDR_RESET}};
        end else if (capture) begin
            pending_reg         <= 1'b1;
            first_error_pointer <= unc_err.bit_pos;
            header_log_word_reg <= unc_err.hdr;
        end else if (unc_ack) begin
            pending_reg <= 1'b0;
        end
    end

    // report upward only unmasked events; the interrupt follows unmasked status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            corr_report <= 1'b0;
            irq         <= 1'b0;
        end else begin
            corr_report <= |(events & ~correctable_mask_reg);
            irq         <= |(correctable_status_reg & ~correctable_mask_reg);
        end
    end

    a_masked_no_report: assert property (@(posedge aclk) disable iff (!aresetn)
        ((events & ~correctable_mask_reg) == 32'h0000_0000) |=> !corr_report)
        else $error("masked event was reported");

    a_event_recorded: assert property (@(posedge aclk) disable iff (!aresetn)
        (events != 32'h0000_0000)
        |=> ((correctable_status_reg & $past(events)) == $past(events)))
        else $error("correctable event not recorded");

    a_mask_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 ((correctable_mask_reg & ~amh_pkg::AMH_CORR_DEFINED) == 32'h0000_0000))
        else $error("reserved mask bit set");

    a_ctl_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && $past(addr_hit(s_axi_araddr, amh_pkg::AMH_ERR_CTL_OFF)
                              && s_axi_arvalid && s_axi_arready)
        |-> s_axi_rdata[31:9] == 23'h000000)
        else $error("control reserved bits read nonzero");

    a_hot_keeps_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        hot_reset && !do_write |=> $stable(correctable_mask_reg) && $stable(crc_gen_en)
                                   && crc_gen_capable_reg && crc_check_capable_reg)
        else $error("hot reset disturbed sticky state");

    a_log_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
        pending_reg && !unc_ack |=> $stable(header_log_word_reg)
                                    && $stable(first_error_pointer))
        else $error("header log overwritten while pending");

    a_log_loaded: assert property (@(posedge aclk) disable iff (!aresetn)
        unc_err.valid && !pending_reg
        |=> header_log_word_reg == $past(unc_err.hdr)
            && first_error_pointer == $past(unc_err.bit_pos) && pending_reg)
        else $error("header log not captured");

    a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        (correctable_status_reg & ~correctable_mask_reg) != 32'h0000_0000 |=> irq)
        else $error("interrupt missing for unmasked status");

    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ctl && wstrb_reg[0] |=> s_axi_bvalid
            && crc_gen_en == $past(wdata_reg[amh_pkg::AMH_GEN_EN_BIT]))
        else $error("control write not applied or not answered");

endmodule

`default_nettype wire

//--- test/amh_host_model.sv
// axi4-lite master standing in for the configuration software of the root complex
`default_nettype none

module amh_host_model (
    input  wire logic        aclk,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [11:0]      awaddr,
    output logic             wvalid,
    input  wire logic        wready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    input  wire logic        bvalid,
    output logic             bready,
    input  wire logic [1:0]  bresp,
    output logic             arvalid,
    input  wire logic        arready,
    output logic [11:0]      araddr,
    input  wire logic        rvalid,
    output logic             rready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 60'h0;
    end

    // write: both channels offered at once, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'h7;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr  <= ~a; // released lines must not keep the old address
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    // read: address held until taken, rready held until the data comes
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule

`default_nettype wire

//--- test/tb_aer_mask_control_header_log.sv
// self-checking bench of the error mask, control and header log registers
`default_nettype none

module tb_aer_mask_control_header_log;
    timeunit 1ns;
    timeprecision 1ps;

    logic              aclk = 1'b0, aresetn = 1'b0, hot_reset = 1'b0, cfg_unlock = 1'b0;
    logic              unc_ack = 1'b0, irq, corr_report, crc_gen_en, crc_chk_en;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [1:0]        bresp, rresp, resp;
    logic [3:0]        wstrb;
    logic [4:0]        first_error_pointer;
    logic [11:0]       awaddr, araddr;
    logic [31:0]       wdata, rdata, rd_data, corr_event = 32'h0;
    amh_pkg::amh_unc_t unc_err = '0;
    int                bad_count = 0, compares = 0;
    int unsigned       corr_bits [6] = '{0, 6, 7, 8, 12, 13};

    amh_aer_regs DUT (.aclk(aclk), .aresetn(aresetn), .hot_reset(hot_reset),
        .cfg_unlock(cfg_unlock), .corr_event(corr_event), .unc_err(unc_err), .unc_ack(unc_ack),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .irq(irq), .corr_report(corr_report), .crc_gen_en(crc_gen_en),
        .crc_chk_en(crc_chk_en), .first_error_pointer(first_error_pointer));

    amh_host_model u_host (.aclk(aclk), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp));

    // 250 mhz core clock
    initial begin
        forever #2 aclk = ~aclk;
    end

    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        u_host.rd(a, rd_data, resp);
        chk($sformatf("resp at %h", a), 32'h0, {30'h0, resp});
        chk($sformatf("reg at %h", a), e, rd_data);
    endtask

    task automatic wreg(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        u_host.wr(a, d, s, resp);
        chk($sformatf("wresp at %h", a), 32'h0, {30'h0, resp});
    endtask

    // event pulse; report seen one edge later, interrupt one edge after that
    task automatic corr_pulse(input int unsigned b, input logic rep);
        @(posedge aclk);
        corr_event <= 32'h1 << b;
        @(posedge aclk);
        corr_event <= 32'h0;
        #1;
        chk("corr_report", {31'h0, rep}, {31'h0, corr_report});
        @(posedge aclk);
        #1;
        chk("irq", {31'h0, rep}, {31'h0, irq});
        chk("corr_report pulse", 32'h0, {31'h0, corr_report});
    endtask

    task automatic unc(input logic [4:0] p, input logic [31:0] b, input logic ack);
        @(posedge aclk);
        unc_err <= {1'b1, p, b + 32'h3, b + 32'h2, b + 32'h1, b};
        unc_ack <= ack;
        @(posedge aclk);
        unc_err.valid <= 1'b0;
        unc_ack <= 1'b0;
    endtask

    task automatic logs(input logic [31:0] b, input logic [31:0] step);
        for (int k = 0; k < 4; k++)
            rchk(amh_pkg::AMH_HDR_LOG0_OFF + 12'(4 * k), b + step * 32'(k));
    endtask

    task automatic pulse_reset(input logic fund);
        @(posedge aclk);
        if (fund) begin
            aresetn <= 1'b0;
            repeat (8) @(posedge aclk);
            aresetn <= 1'b1;
        end else begin
            hot_reset <= 1'b1;
            @(posedge aclk);
            hot_reset <= 1'b0;
        end
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        summarize();
    end

    // main sequence
    initial begin
        pulse_reset(1'b1);
        rchk(amh_pkg::AMH_CORR_MASK_OFF, 32'h0000_2000);
        rchk(amh_pkg::AMH_ERR_CTL_OFF, 32'h0000_00a0);
        rchk(amh_pkg::AMH_CORR_STATUS_OFF, 32'h0);
        logs(32'h0, 32'h0);
        corr_pulse(13, 1'b0);
        rchk(amh_pkg::AMH_CORR_STATUS_OFF, 32'h0000_2000);
        wreg(amh_pkg::AMH_CORR_STATUS_OFF, 32'hffff_ffff, 4'hf);
        wreg(amh_pkg::AMH_CORR_MASK_OFF, 32'hffff_ffff, 4'h1);
        rchk(amh_pkg::AMH_CORR_MASK_OFF, 32'h0000_20c1);
        wreg(amh_pkg::AMH_CORR_MASK_OFF, 32'hffff_ffff, 4'hf);
        rchk(amh_pkg::AMH_CORR_MASK_OFF, 32'h0000_31c1);
        wreg(amh_pkg::AMH_CORR_MASK_OFF, 32'h0, 4'hf);
        // each event unmasked, then masked: still recorded, never reported
        foreach (corr_bits[i]) begin
            corr_pulse(corr_bits[i], 1'b1);
            rchk(amh_pkg::AMH_CORR_STATUS_OFF, 32'h1 << corr_bits[i]);
            wreg(amh_pkg::AMH_CORR_STATUS_OFF, 32'h1 << corr_bits[i], 4'hf);
            rchk(amh_pkg::AMH_CORR_STATUS_OFF, 32'h0);
            chk("irq cleared", 32'h0, {31'h0, irq});
            wreg(amh_pkg::AMH_CORR_MASK_OFF, 32'h1 << corr_bits[i], 4'hf);
            corr_pulse(corr_bits[i], 1'b0);
            rchk(amh_pkg::AMH_CORR_STATUS_OFF, 32'h1 << corr_bits[i]);
            wreg(amh_pkg::AMH_CORR_STATUS_OFF, 32'hffff_ffff, 4'hf);
            wreg(amh_pkg::AMH_CORR_MASK_OFF, 32'h0, 4'hf);
        end
        // capability bits hold unless unlocked; enables reach the ports
        wreg(amh_pkg::AMH_ERR_CTL_OFF, 32'hffff_ffff, 4'hf);
        rchk(amh_pkg::AMH_ERR_CTL_OFF, 32'h0000_01e0);
        chk("crc enables", 32'h3, {30'h0, crc_chk_en, crc_gen_en});
        cfg_unlock <= 1'b1;
        wreg(amh_pkg::AMH_ERR_CTL_OFF, 32'h0000_0100, 4'hf);
        cfg_unlock <= 1'b0;
        rchk(amh_pkg::AMH_ERR_CTL_OFF, 32'h0000_0100);
        chk("crc enables", 32'h2, {30'h0, crc_chk_en, crc_gen_en});
        wreg(amh_pkg::AMH_CORR_MASK_OFF, 32'h0000_1001, 4'hf);
        pulse_reset(1'b0);
        rchk(amh_pkg::AMH_ERR_CTL_OFF, 32'h0000_01a0);
        rchk(amh_pkg::AMH_CORR_MASK_OFF, 32'h0000_1001);
        // first error logged; a later one is dropped until acknowledged
        unc(5'h12, 32'h1000_0000, 1'b0);
        rchk(amh_pkg::AMH_ERR_CTL_OFF, 32'h0000_01b2);
        chk("pointer", 32'h12, {27'h0, first_error_pointer});
        logs(32'h1000_0000, 32'h1);
        u_host.wr(amh_pkg::AMH_HDR_LOG0_OFF, 32'hffff_ffff, 4'hf, resp);
        chk("log write bresp", 32'h0, {30'h0, resp});
        unc(5'h04, 32'h2000_0000, 1'b0);
        logs(32'h1000_0000, 32'h1);
        rchk(amh_pkg::AMH_ERR_CTL_OFF, 32'h0000_01b2);
        unc(5'h07, 32'h3000_0000, 1'b1);
        rchk(amh_pkg::AMH_ERR_CTL_OFF, 32'h0000_01a7);
        pulse_reset(1'b0);
        logs(32'h3000_0000, 32'h1);
        rchk(amh_pkg::AMH_ERR_CTL_OFF, 32'h0000_01a7);
        pulse_reset(1'b1);
        rchk(amh_pkg::AMH_CORR_MASK_OFF, 32'h0000_2000);
        rchk(amh_pkg::AMH_ERR_CTL_OFF, 32'h0000_00a0);
        logs(32'h0, 32'h0);
        // unmapped place refused on both paths
        u_host.rd(12'h200, rd_data, resp);
        chk("unmapped rresp", 32'h3, {30'h0, resp});
        chk("unmapped rdata", 32'h0, rd_data);
        u_host.wr(12'h200, 32'hffff_ffff, 4'hf, resp);
        chk("unmapped bresp", 32'h3, {30'h0, resp});
        summarize();
    end
endmodule

`default_nettype wire
